// ---- rtl/sew_line_sync.sv ----
// Two-flop synchroniser and edge finder for the serial clock and data pins
`timescale 1ns/1ps
module sew_line_sync
(
   // Clock and reset
   input  wire  logic                  clk_sys,
   input  wire  logic                  nrst,
   // Raw pins
   input  wire  sew_pkg::sew_pins_in_t pins,
   // Clean levels and events
   output logic                        scl,
   output logic                        sda,
   output logic                        scl_rise,
   output logic                        scl_fall,
   output logic                        start_seen,
   output logic                        stop_seen
);
   import sew_pkg::*;

   // All state in one struct
   typedef struct packed {
      logic [1:0] meta;   // First stage, read only by the second
      logic [1:0] sync;   // Second stage
      logic [1:0] last;   // Previous clean value for edges
   } sew_sync_st_t;

   sew_sync_st_t st;      // Registered state
   sew_sync_st_t next_st; // Next state

   // Shift the pins through the chain
   always_comb
   begin
      next_st      = st;
      next_st.meta = {pins.scl_in, pins.sda_in};
      next_st.sync = st.meta;
      next_st.last = st.sync;
   end

   // Idle bus reads high, so reset to ones to avoid a false start
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         st <= '{meta: 2'h3, sync: 2'h3, last: 2'h3};
      else
         st <= next_st;
   end

   // Levels and one-cycle events
   assign scl        = st.sync[1];
   assign sda        = st.sync[0];
   assign scl_rise   = st.sync[1] & ~st.last[1];
   assign scl_fall   = ~st.sync[1] & st.last[1];
   // Data edges only count while the clock stays high
   assign start_seen = st.sync[1] & st.last[1] & st.last[0] & ~st.sync[0];
   assign stop_seen  = st.sync[1] & st.last[1] & ~st.last[0] & st.sync[0];
endmodule

// ---- rtl/sew_pkg.sv ----
// Package: constants and carrier types for the two-wire memory slave
package sew_pkg;

   // Variant selection: 0 = 256 bytes, 1 = 512 bytes, 2 = 1024 bytes
   localparam int SEW_VARIANT_SMALL  = 0;
   localparam int SEW_VARIANT_MIDDLE = 1;
   localparam int SEW_VARIANT_LARGE  = 2;

   // Word size on the link and bit slot index of the acknowledge
   localparam int SEW_WORD_BITS      = 8;
   localparam int SEW_ACK_SLOT       = 8;

   // Fixed four-bit prefix of the select byte
   localparam logic [3:0] SEW_SELECT_PREFIX = 4'hA;

   // Page sizes in bytes
   localparam int SEW_PAGE_SMALL     = 8;
   localparam int SEW_PAGE_LARGE     = 16;

   // Programming time, printed in microseconds, and derived cycles
   localparam int SEW_CLK_MHZ        = 40;
   localparam int SEW_PROG_TIME_US   = 4000;
   localparam int SEW_PROG_CYCLES    = SEW_PROG_TIME_US * SEW_CLK_MHZ;

   // Reset values
   localparam logic [9:0] SEW_ADDR_RESET = 10'h000;
   localparam logic [7:0] SEW_BYTE_RESET = 8'h00;

   // Protocol phases of the slave
   typedef enum logic [2:0] {
      SEW_IDLE,
      SEW_SELECT,
      SEW_WORD_ADDR,
      SEW_WRITE_DATA,
      SEW_READ_DATA,
      SEW_READ_ACK
   } sew_phase_t;

   // Bus pins as seen by the design: clock in, data in, data out and enable
   typedef struct packed {
      logic scl_in;
      logic sda_in;
   } sew_pins_in_t;

   typedef struct packed {
      logic sda_out;
      logic sda_oe;
   } sew_pins_out_t;

   // One write into the page buffer
   typedef struct packed {
      logic       we;
      logic [3:0] idx;
      logic [7:0] data;
   } sew_buf_wr_t;

endpackage

// ---- rtl/sew_slave.sv ----
// Two-wire serial memory slave: framing, select decode, page write and read
`timescale 1ns/1ps
// Summary of operation
// - Data changes only while clock is low
// - Start condition precedes every accepted command
// - Stop after read returns to standby
// - Eight-bit words, acknowledged low on ninth clock
// - Standby at power-up, and after stop once any programming ends
// - Sample on rise, change after fall
// - Data output is open-drain only
// - Write-protect high makes array read-only
// - Middle variant compares pins two, one
// - Large variant compares pin two only
// - Array holds 256, 512 or 1024 bytes
// - Pages of 8 or 16 bytes
// - Partial page programs only received bytes
// - Self-timed programming finishes within 4 ms
// - Select byte: prefix, select bits, read flag
// - Page write wraps within page
// - Counter keeps next address, read wraps memory
module sew_slave
#(
   parameter int VARIANT     = 0,                        // 0/1/2 selects 256/512/1024 bytes
   parameter int PROG_CYCLES = sew_pkg::SEW_PROG_CYCLES  // Programming time in cycles
)
(
   // Clock and reset
   input  wire  logic                   clk_sys,
   input  wire  logic                   nrst,
   // Two-wire bus
   input  wire  sew_pkg::sew_pins_in_t  pins,
   output sew_pkg::sew_pins_out_t       pins_out,
   // Hard-wired straps
   input  wire  logic                   chip_select_pin_0,
   input  wire  logic                   chip_select_pin_1,
   input  wire  logic                   chip_select_pin_2,
   input  wire  logic                   write_protect,
   // Status
   output logic                         standby,
   output logic                         programming
);
   import sew_pkg::*;

   // Geometry derived from the variant
   localparam int AW   = (VARIANT == SEW_VARIANT_SMALL) ? 8 : (VARIANT == SEW_VARIANT_MIDDLE) ? 9 : 10;
   localparam int PW   = (VARIANT == SEW_VARIANT_SMALL) ? 3 : 4;
   localparam int SIZE = 1 << AW;
   localparam int PAGE = (VARIANT == SEW_VARIANT_SMALL) ? SEW_PAGE_SMALL : SEW_PAGE_LARGE;

   // Select byte check; page bits are not compared on larger variants
   function automatic logic select_match(input logic [7:0] b, input logic [2:0] pinv);
      logic ok;
      ok = (b[7:4] == SEW_SELECT_PREFIX);
      ok = ok & (b[3] == pinv[2]);
      if (VARIANT != SEW_VARIANT_LARGE)
         ok = ok & (b[2] == pinv[1]);
      if (VARIANT == SEW_VARIANT_SMALL)
         ok = ok & (b[1] == pinv[0]);
      return ok;
   endfunction

   // Page bits taken from the select byte
   function automatic logic [1:0] page_bits(input logic [7:0] b);
      return (VARIANT == SEW_VARIANT_LARGE) ? b[2:1] : (VARIANT == SEW_VARIANT_MIDDLE) ? {1'b0, b[1]} : 2'h0;
   endfunction

   // All control state in one struct; array and page buffer are held apart
   typedef struct packed {
      sew_phase_t      phase;     // Protocol phase
      logic [3:0]      bitcnt;    // Bit slot within a frame, 8 = acknowledge
      logic [7:0]      shift;     // Receive shift register
      logic [7:0]      tx;        // Transmit shift register
      logic [9:0]      addr;      // Internal address counter
      logic [9:0]      wbase;     // Page start of a pending write
      logic [PAGE-1:0] wmask;     // Bytes received for the page
      logic            pend;      // Page data waiting for stop
      logic            prog;      // Programming cycle running
      logic [31:0]     timer;     // Programming countdown
      logic            pull;      // Driving the data line low
      logic            ack_due;   // Acknowledge slot owed to master
      logic            nack;      // Master refused the last read byte
      logic [3:0]      strap_meta; // Protect pin and straps, first stage
      logic [3:0]      strap;      // Protect pin and straps, second stage
   } sew_st_t;

   sew_st_t st;       // Registered state
   sew_st_t next_st;  // Next state

   // Storage: array and page buffer
   logic [7:0] mem  [SIZE];  // Nonvolatile array model
   logic [7:0] pbuf [PAGE];  // Received page bytes

   // Synchronised bus
   logic sda, scl_rise, scl_fall, start_seen, stop_seen;   // Clock level itself is unused, only its edges
   sew_buf_wr_t bw;           // Page-buffer write request
   logic        commit;       // Last cycle of programming
   logic [2:0]  pinv;         // Straps as a vector

   assign pinv = st.strap[2:0]; // Straps after the two-flop stage

   // Pins pass two flops before any logic looks at them
   sew_line_sync u_sync
   (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .pins       (pins),
      .scl        (),
      .sda        (sda),
      .scl_rise   (scl_rise),
      .scl_fall   (scl_fall),
      .start_seen (start_seen),
      .stop_seen  (stop_seen)
   );

   // Protocol engine
   always_comb
   begin
      next_st = st;
      bw      = '{we: 1'b0, idx: 4'h0, data: 8'h00};
      commit  = 1'b0;
      // Straps and protect are pins as well, so they pass two flops before use
      next_st.strap_meta = {write_protect, chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
      next_st.strap      = st.strap_meta;
      // Programming countdown runs on its own clock, no serial clocks needed
      if (st.prog)
      begin
         if (st.timer == 32'h0)
         begin
            next_st.prog = 1'b0;
            commit       = 1'b1;
         end
         else
            next_st.timer = st.timer - 32'h1;
      end
      if (start_seen)
      begin
         // Start restarts framing; a pending write is dropped by a repeated start
         next_st.phase  = SEW_SELECT;
         // The clock fall that closes the start is no data bit; it wraps this to 0
         next_st.bitcnt = 4'hF;
         next_st.pull   = 1'b0;
         next_st.pend   = 1'b0;
      end
      else if (stop_seen)
      begin
         next_st.phase = SEW_IDLE;
         next_st.pull  = 1'b0;
         // Protected writes never start programming
         if (st.pend && !st.strap[3])
         begin
            next_st.prog  = 1'b1;
            next_st.timer = 32'(PROG_CYCLES - 1);
         end
         next_st.pend = 1'b0;
      end
      else if (st.phase != SEW_IDLE && scl_rise)
      begin
         // Sample on the rising clock edge
         if (st.bitcnt == 4'(SEW_ACK_SLOT))
         begin
            if (st.phase == SEW_READ_ACK)
               next_st.nack = sda;
         end
         else
            next_st.shift = {st.shift[6:0], sda};
      end
      else if (st.phase != SEW_IDLE && scl_fall)
      begin
         // Change outputs just after the falling edge
         next_st.pull = 1'b0;
         if (st.bitcnt == 4'(SEW_ACK_SLOT - 1))
         begin
            // Eighth bit done: decide the ninth slot
            next_st.bitcnt  = st.bitcnt + 4'h1;
            next_st.ack_due = 1'b1;
            case (st.phase)
               SEW_SELECT:
               begin
                  if (st.prog || !select_match(st.shift, pinv))
                  begin
                     next_st.phase = SEW_IDLE;
                     next_st.ack_due = 1'b0;
                  end
                  else
                  begin
                     next_st.pull = 1'b1;
                     next_st.addr = {page_bits(st.shift), st.addr[7:0]};
                     next_st.phase = st.shift[0] ? SEW_READ_DATA : SEW_WORD_ADDR;
                  end
               end
               SEW_WORD_ADDR:
               begin
                  next_st.pull  = 1'b1;
                  next_st.addr  = {st.addr[9:8], st.shift};
                  next_st.wbase = {st.addr[9:8], st.shift} & ~10'(PAGE - 1);
                  next_st.wmask = '0;
                  next_st.phase = SEW_WRITE_DATA;
               end
               SEW_WRITE_DATA:
               begin
                  // Still acknowledged under protection
                  next_st.pull  = 1'b1;
                  bw            = '{we: 1'b1, idx: 4'(st.addr[PW-1:0]), data: st.shift};
                  next_st.wmask = st.wmask | (PAGE'(1) << st.addr[PW-1:0]);
                  next_st.pend  = 1'b1;
                  // Only the in-page bits advance
                  next_st.addr  = (st.addr & ~10'(PAGE - 1)) | 10'((st.addr[PW-1:0] + PW'(1)));
               end
               SEW_READ_DATA:
               begin
                  // Master owns the ninth slot after a read byte
                  next_st.ack_due = 1'b0;
                  next_st.phase   = SEW_READ_ACK;
               end
               default:
                  next_st.phase = SEW_IDLE;
            endcase
         end
         else if (st.bitcnt == 4'(SEW_ACK_SLOT))
         begin
            // Ninth slot over: start next word
            next_st.bitcnt  = 4'h0;
            next_st.ack_due = 1'b0;
            if (st.phase == SEW_READ_DATA || st.phase == SEW_READ_ACK)
            begin
               if (st.phase == SEW_READ_ACK && st.nack)
                  next_st.phase = SEW_IDLE;                            // Wait for stop
               else
               begin
                  next_st.phase = SEW_READ_DATA;
                  next_st.tx    = {mem[st.addr[AW-1:0]][6:0], 1'b0};
                  next_st.pull  = ~mem[st.addr[AW-1:0]][7];
                  // Read counter wraps over the whole array
                  next_st.addr  = 10'(st.addr[AW-1:0] + AW'(1));
               end
            end
         end
         else
         begin
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.phase == SEW_READ_DATA)
            begin
               next_st.pull = ~st.tx[7];
               next_st.tx   = {st.tx[6:0], 1'b0};
            end
         end
      end
   end

   // State register; address counter survives between operations
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         st <= '{phase: SEW_IDLE, bitcnt: 4'h0, shift: SEW_BYTE_RESET, tx: SEW_BYTE_RESET,
                 addr: SEW_ADDR_RESET, wbase: SEW_ADDR_RESET, wmask: '0, pend: 1'b0,
                 prog: 1'b0, timer: 32'h0, pull: 1'b0, ack_due: 1'b0, nack: 1'b0,
                 strap_meta: 4'h0, strap: 4'h0};
      else
         st <= next_st;
   end

   // Page buffer capture
   always_ff @(posedge clk_sys)
   begin
      if (bw.we)
         pbuf[bw.idx[PW-1:0]] <= bw.data;
   end

   // Commit only the bytes actually received
   // One process owns the array, so it has a single writer
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < PAGE; i++)
      begin
         if (commit && st.wmask[i])
            mem[st.wbase[AW-1:0] | AW'(i)] <= pbuf[i];
      end
   end

   // Open drain: only ever pull low
   assign pins_out         = '{sda_out: 1'b0, sda_oe: st.pull};
   assign standby          = (st.phase == SEW_IDLE) & ~st.prog;
   assign programming      = st.prog;
endmodule

// ---- verification/sew_master_model.sv ----
// Bus master model: drives clock, releases data to the pull-up
`timescale 1ns/1ps
module sew_master_model
(
   // System clock
   input  wire logic clk_sys,
   // Wired data level
   input  wire logic line,
   // Driven pins, data 1 is released
   output logic      scl,
   output logic      sda
);
   // Idle bus: both high, clock stands still
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // One bit: data moves in low time, sampled at end of high time
   task automatic bit_x(input logic b, output logic r);
      sda <= b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      r = line;
      scl <= 1'b0;
      tick(2);
   endtask
   // Long low time first so a slave pull is gone before the rise
   task automatic start();
      sda <= 1'b1;
      tick(6);
      scl <= 1'b1;
      tick(4);
      sda <= 1'b0;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic stop();
      sda <= 1'b0;
      tick(6);
      scl <= 1'b1;
      tick(4);
      sda <= 1'b1;
      tick(4);
   endtask
   // Clock until the line is seen high, then start
   task automatic recover();
      logic r;
      for (int i = 0; i < 9; i++)
      begin
         bit_x(1'b1, r);
         if (r)
            break;
      end
      start();
   endtask
   // MSB first, then the acknowledge slot
   task automatic wr_byte(input logic [7:0] d, output logic nak);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, nak);
   endtask
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++)
      begin
         bit_x(1'b1, r);
         d = {d[6:0], r};
      end
      bit_x(last, r);
   endtask
endmodule

// ---- verification/sew_slave_monitor.sv ----
// Port checker of the two-wire memory slave
`timescale 1ns/1ps
module sew_slave_monitor
#(
   parameter int VARIANT     = 0,  // Size selector
   parameter int PROG_CYCLES = sew_pkg::SEW_PROG_CYCLES // Programming cycles
)
(
   // Clock and reset
   input wire logic                   clk_sys,
   input wire logic                   nrst,
   // Bus pins
   input wire sew_pkg::sew_pins_in_t  pins,
   input wire sew_pkg::sew_pins_out_t pins_out,
   // Straps
   input wire logic                   chip_select_pin_0,
   input wire logic                   chip_select_pin_1,
   input wire logic                   chip_select_pin_2,
   input wire logic                   write_protect,
   // Status
   input wire logic                   standby,
   input wire logic                   programming
);
   import sew_pkg::*;
   int prog_len; // Cycles of the running burst
   // Count programming time, cleared while idle
   always_ff @(posedge clk_sys)
   begin
      if (!nrst || !programming)
         prog_len <= 0;
      else
         prog_len <= prog_len + 1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_open_drain: assert property (pins_out.sda_out == 1'b0)
      else $error("data pin driven high");
   a_reset_state: assert property ($rose(nrst) |-> standby && !programming && !pins_out.sda_oe)
      else $error("bad state after reset");
   a_busy_silent: assert property (programming |-> !standby && !pins_out.sda_oe)
      else $error("answer or standby while programming");
   a_prog_length: assert property ($fell(programming) |-> prog_len == PROG_CYCLES)
      else $error("programming length wrong");
   a_idle_released: assert property (standby |-> !pins_out.sda_oe)
      else $error("line pulled in standby");
   // Three high samples: the slave must not move the line mid high time
   a_still_on_high: assert property (pins.scl_in && $past(pins.scl_in) && $past(pins.scl_in, 2)
      |-> $stable(pins_out.sda_oe))
      else $error("line moved while clock high");
   a_ack_stands: assert property ($rose(pins_out.sda_oe) |-> pins_out.sda_oe[*4])
      else $error("pull released too soon");
   a_protect_blocks: assert property ($rose(programming) |-> !$past(write_protect) && !write_protect)
      else $error("programming under protection");
endmodule

bind sew_slave sew_slave_monitor #(.VARIANT(VARIANT), .PROG_CYCLES(PROG_CYCLES)) u_mon
(
   .clk_sys(clk_sys), .nrst(nrst), .pins(pins), .pins_out(pins_out),
   .chip_select_pin_0(chip_select_pin_0), .chip_select_pin_1(chip_select_pin_1),
   .chip_select_pin_2(chip_select_pin_2), .write_protect(write_protect),
   .standby(standby), .programming(programming)
);

// ---- verification/tb_serial_eeprom_two_wire_slave.sv ----
// Self-checking bench of the two-wire memory slave
`timescale 1ns/1ps
module tb_serial_eeprom_two_wire_slave;
   import sew_pkg::*;
   localparam int PROG = 200; // Shortened programming time
   localparam logic [7:0] SW = {SEW_SELECT_PREFIX, 3'b101, 1'b0}; // Straps 2,1,0 = 1,0,1
   logic          clk_sys, nrst, wp, m_scl, m_sda, line, standby, programming, nak;
   logic [2:0]    cs;
   logic [7:0]    q[$];
   sew_pins_in_t  pins;
   sew_pins_out_t pins_out;
   int            mismatches = 0;
   int            compares = 0;
   int            cycles = 0;
   // Wired line: low if either side pulls
   assign line = m_sda & ~pins_out.sda_oe;
   assign pins = '{scl_in: m_scl, sda_in: line};
   sew_slave #(.VARIANT(SEW_VARIANT_SMALL), .PROG_CYCLES(PROG)) dut
   (
      .clk_sys(clk_sys), .nrst(nrst), .pins(pins), .pins_out(pins_out),
      .chip_select_pin_0(cs[0]), .chip_select_pin_1(cs[1]), .chip_select_pin_2(cs[2]),
      .write_protect(wp), .standby(standby), .programming(programming)
   );
   sew_master_model m (.clk_sys(clk_sys), .line(line), .scl(m_scl), .sda(m_sda));
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         $display("[FAIL] %0t timeout", $time);
         conclude();
      end
   end
   task automatic conclude();
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   // Send a byte and judge the acknowledge slot
   task automatic send(input logic [7:0] b, input logic exp_nak);
      m.wr_byte(b, nak);
      chk(nak === exp_nak, "ack slot wrong");
   endtask
   task automatic page_write(input logic [7:0] a, input logic [7:0] d[$]);
      m.start();
      send(SW, 1'b0);
      send(a, 1'b0);
      foreach (d[i])
         send(d[i], 1'b0);
      m.stop();
   endtask
   // Dummy write loads the address, repeated start reads n bytes
   task automatic read_from(input logic [7:0] a, input int n);
      logic [7:0] b;
      q = {};
      m.start();
      send(SW, 1'b0);
      send(a, 1'b0);
      m.start();
      send(SW | 8'h01, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         m.rd_byte(i == n - 1, b);
         q.push_back(b);
      end
      m.stop();
   endtask
   task automatic wait_prog();
      for (int k = 0; k < PROG + 20 && programming !== 1'b0; k++)
         @(posedge clk_sys);
      @(posedge clk_sys);
      chk(standby === 1'b1, "no standby after programming");
   endtask
   // Write, poll while busy, then read back
   task automatic t_write_poll();
      page_write(8'h10, {8'h5A});
      chk(programming === 1'b1, "no programming after stop");
      m.start();
      send(SW, 1'b1);
      m.stop();
      chk(programming === 1'b1, "programming ended early");
      wait_prog();
      read_from(8'h10, 1);
      chk(q[0] === 8'h5A, "byte write lost");
   endtask
   // Page 0 from offset 6: four bytes wrap inside the 8-byte page
   task automatic t_page_wrap();
      page_write(8'h06, {8'h11, 8'h22, 8'h33, 8'h44});
      wait_prog();
      read_from(8'h00, 2);
      chk(q[0] === 8'h33 && q[1] === 8'h44, "page did not wrap");
      read_from(8'h06, 2);
      chk(q[0] === 8'h11 && q[1] === 8'h22, "page start bytes wrong");
      page_write(8'hFF, {8'h77});
      wait_prog();
      read_from(8'hFF, 2);
      chk(q[0] === 8'h77 && q[1] === 8'h33, "read did not wrap");
   endtask
   task automatic t_protect();
      wp <= 1'b1;
      page_write(8'h10, {8'hEE});
      @(posedge clk_sys);
      chk(programming === 1'b0, "protected write programmed");
      wp <= 1'b0;
      read_from(8'h10, 1);
      chk(q[0] === 8'h5A, "protected byte altered");
   endtask
   // Each wrong strap bit and a wrong prefix go unanswered
   task automatic t_select();
      logic [7:0] bad[4] = '{SW ^ 8'h02, SW ^ 8'h04, SW ^ 8'h08, SW ^ 8'h40};
      foreach (bad[i])
      begin
         m.start();
         send(bad[i], 1'b1);
         chk(standby === 1'b1, "not idle after mismatch");
         m.stop();
      end
      cs <= 3'b010;
      m.start();
      send({SEW_SELECT_PREFIX, 3'b010, 1'b0}, 1'b0);
      m.stop();
      cs <= 3'b101;
   endtask
   initial
   begin
      nrst = 1'b0;
      wp = 1'b0;
      cs = 3'b101;
      repeat (3) @(posedge clk_sys);
      chk(standby === 1'b1 && programming === 1'b0 && pins_out.sda_oe === 1'b0, "reset state");
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      m.recover();
      m.stop();
      t_write_poll();
      t_page_wrap();
      t_protect();
      t_select();
      conclude();
   end
endmodule
